// File: hw/isb_serializer.sv
`timescale 1ns/1ps
// Functional notes
// [RULE1] Undervoltage bit low below lower threshold.
// [RULE2] Temperature bit low while overheated, hysteresis.
// [RULE3] Check bits sit in positions two to five.
// [RULE4] Check bits use exclusive-NOR.
// [RULE5] Sleep on supply loss, output held low.
// [RULE6] Last bit is high stop bit.
// [RULE7] Power reset low disables normal output.
// [RULE8] Chip select high floats both outputs.
// [RULE9] Inverted output complements true output.
// [RULE10] Power loss drives true low, inverted high.
// [RULE11] Frame order: stops, checks, alarms, inputs.
// [RULE12] Load on select fall, shift falling, MSB first.
// [RULE13] Capture input data on rising clock.
// [RULE14] Snapshot latched when select falls.
module isb_serializer (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Serial link pins; inputs asynchronous to clk, outputs registered on clk.
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe,
  output logic miso_n_o,
  output logic miso_n_oe,
  // Monitor levels from the analog comparators.
  input wire logic supply_voltage_monitor_lo,
  input wire logic supply_voltage_monitor_hi,
  input wire logic temp_above_on,
  input wire logic temp_below_off,
  input wire logic power_good,
  // Filtered input states, inputs one to eight.
  input wire logic [isb_pkg::IN_W-1:0] in_state,
  // Received word stream.
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [isb_pkg::FRAME_W-1:0] rx_data,
  output logic rx_overrun
);

  // Two-flop synchronisers for every pin and monitor level.
  localparam int NSYNC = 9 + isb_pkg::IN_W;
  // Reset image of the chain: select idles high, so that no false select edge follows reset.
  localparam logic [NSYNC-1:0] SYNC_RST = NSYNC'(1) << (NSYNC - 2);
  logic [NSYNC-1:0] s1_ff;
  logic [NSYNC-1:0] s2_ff;
  wire [NSYNC-1:0] async_in = {sck, cs_n, mosi, supply_voltage_monitor_lo, supply_voltage_monitor_hi,
                               temp_above_on, temp_below_off, power_good, 1'b0, in_state};

  // Synchroniser chain; the first stage feeds only the second.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= SYNC_RST;
      s2_ff <= SYNC_RST;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
    end
  end

  // Named views of the synchronised levels.
  wire sck_s = s2_ff[NSYNC-1];
  wire cs_n_s = s2_ff[NSYNC-2];
  wire mosi_s = s2_ff[NSYNC-3];
  wire uv_lo_s = s2_ff[NSYNC-4];
  wire uv_hi_s = s2_ff[NSYNC-5];
  wire t_on_s = s2_ff[NSYNC-6];
  wire t_off_s = s2_ff[NSYNC-7];
  wire pg_s = s2_ff[NSYNC-8];
  wire [isb_pkg::IN_W-1:0] in_s = s2_ff[isb_pkg::IN_W-1:0];

  // Edge history of clock and select.
  logic sck_d_ff;
  logic cs_n_d_ff;
  wire sck_rise = sck_s && !sck_d_ff;
  wire sck_fall = !sck_s && sck_d_ff;
  wire cs_fall = !cs_n_s && cs_n_d_ff;
  wire cs_rise = cs_n_s && !cs_n_d_ff;

  // Alarm hysteresis latches, low active.
  logic uva_n_ff;
  logic ota_n_ff;
  wire nxt_uva_n = uv_lo_s ? 1'b0 : (uv_hi_s ? 1'b1 : uva_n_ff); // [RULE1]
  wire nxt_ota_n = t_on_s ? 1'b0 : (t_off_s ? 1'b1 : ota_n_ff); // [RULE2]

  // Frame state.
  isb_pkg::isb_snap_t snap_now;
  logic [isb_pkg::FRAME_W-1:0] tx_sr_ff;
  logic [isb_pkg::FRAME_W-1:0] rx_sr_ff;
  logic [isb_pkg::CNT_W-1:0] rx_cnt_ff;
  logic mosi_cap_ff;
  isb_pkg::isb_drive_t drv_ff;

  assign snap_now.inputs = in_s;
  assign snap_now.uva_n = uva_n_ff;
  assign snap_now.ota_n = ota_n_ff;

  // Check bits over the snapshot, each an inverted parity of a bit group.
  wire [isb_pkg::IN_W-1:0] inb = snap_now.inputs;
  wire chk1 = ~(^{inb[7:4], snap_now.uva_n}); // [RULE4]
  wire chk2 = ~(^{inb[7:6], inb[3:2], snap_now.ota_n}); // [RULE4]
  wire chk3 = ~(^{inb[7], inb[5], inb[3], inb[1], snap_now.uva_n}); // [RULE4]
  wire chk4 = ~(^{inb[6], inb[4], inb[2], inb[0], snap_now.ota_n}); // [RULE4]

  // Frame image assembled from the snapshot.
  logic [isb_pkg::FRAME_W-1:0] frame_img;
  always_comb begin
    frame_img = isb_pkg::FRAME_RST;
    frame_img[isb_pkg::POS_IN_LO +: isb_pkg::IN_W] = snap_now.inputs; // [RULE11]
    frame_img[isb_pkg::POS_UVA] = snap_now.uva_n; // [RULE11]
    frame_img[isb_pkg::POS_OTA] = snap_now.ota_n; // [RULE11]
    frame_img[isb_pkg::POS_CHK1] = chk1; // [RULE3]
    frame_img[isb_pkg::POS_CHK2] = chk2; // [RULE3]
    frame_img[isb_pkg::POS_CHK3] = chk3; // [RULE3]
    frame_img[isb_pkg::POS_CHK4] = chk4; // [RULE3]
    frame_img[isb_pkg::POS_STOP_LO] = 1'b0;
    frame_img[isb_pkg::POS_STOP_HI] = 1'b1; // [RULE6]
  end

  // Output drive selection from select and power state.
  isb_pkg::isb_drive_t nxt_drv;
  always_comb begin
    if (cs_n_s) begin
      nxt_drv = '{true_o: 1'b0, inv_o: 1'b0, oe: 1'b0}; // [RULE8]
    end else if (!pg_s) begin
      nxt_drv = '{true_o: 1'b0, inv_o: 1'b1, oe: 1'b1}; // [RULE5] [RULE7] [RULE10]
    end else begin
      nxt_drv = '{true_o: tx_sr_ff[isb_pkg::FRAME_W-1], inv_o: ~tx_sr_ff[isb_pkg::FRAME_W-1], oe: 1'b1}; // [RULE9]
    end
  end

  // Received-word buffer.
  wire rx_done = cs_rise && (rx_cnt_ff >= isb_pkg::FRAME_LEN);
  wire buf_in_ready;
  wire buf_out_valid;
  wire [isb_pkg::FRAME_W-1:0] buf_out_data;

  isb_buf2 #(
    .WIDTH(isb_pkg::FRAME_W),
    .DEPTH(isb_pkg::BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(rx_done),
    .in_ready(buf_in_ready),
    .in_data(rx_sr_ff),
    .out_valid(buf_out_valid),
    .out_ready(rx_ready && !rx_valid),
    .out_data(buf_out_data)
  );

  // Edge history and alarm latches.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
      uva_n_ff <= 1'b1;
      ota_n_ff <= 1'b1;
    end else begin
      sck_d_ff <= sck_s;
      cs_n_d_ff <= cs_n_s;
      uva_n_ff <= nxt_uva_n;
      ota_n_ff <= nxt_ota_n;
    end
  end

  // Transmit shifter: load on select fall, shift on falling clock.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sr_ff <= isb_pkg::FRAME_RST;
    end else if (cs_fall) begin
      tx_sr_ff <= frame_img; // [RULE12] [RULE14]
    end else if (!cs_n_s && sck_fall) begin
      tx_sr_ff <= {tx_sr_ff[isb_pkg::FRAME_W-2:0], mosi_cap_ff}; // [RULE12] [RULE13]
    end
  end

  // Receive shifter: capture on rising clock, MSB first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mosi_cap_ff <= 1'b0;
      rx_sr_ff <= isb_pkg::FRAME_RST;
      rx_cnt_ff <= '0;
    end else if (cs_fall) begin
      rx_cnt_ff <= '0;
    end else if (!cs_n_s && sck_rise) begin
      mosi_cap_ff <= mosi_s; // [RULE13]
      rx_sr_ff <= {rx_sr_ff[isb_pkg::FRAME_W-2:0], mosi_s}; // [RULE13]
      if (rx_cnt_ff < isb_pkg::FRAME_LEN) rx_cnt_ff <= rx_cnt_ff + 1'b1;
    end
  end

  // Registered outputs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_ff <= '0;
      rx_valid <= 1'b0;
      rx_data <= isb_pkg::FRAME_RST;
      rx_overrun <= 1'b0;
    end else begin
      drv_ff <= nxt_drv;
      if (rx_valid && rx_ready) begin
        rx_valid <= 1'b0;
      end else if (!rx_valid && buf_out_valid && rx_ready) begin
        rx_valid <= 1'b1;
        rx_data <= buf_out_data;
      end
      rx_overrun <= rx_done && !buf_in_ready;
    end
  end

  assign miso_o = drv_ff.true_o;
  assign miso_n_o = drv_ff.inv_o;
  assign miso_oe = drv_ff.oe;
  assign miso_n_oe = drv_ff.oe;

endmodule // isb_serializer

// File: pkg/isb_pkg.sv
// Shared constants and carriers for the input serializer status block.
package isb_pkg;

  // Frame geometry.
  localparam int FRAME_W = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_LEN = 5'h10;

  // Frame bit positions, LSB is the last bit out.
  localparam int POS_STOP_HI = 0;
  localparam int POS_STOP_LO = 1;
  localparam int POS_CHK4 = 2;
  localparam int POS_CHK3 = 3;
  localparam int POS_CHK2 = 4;
  localparam int POS_CHK1 = 5;
  localparam int POS_OTA = 6;
  localparam int POS_UVA = 7;
  localparam int POS_IN_LO = 8;
  localparam int IN_W = 8;

  // Buffer depth of the received word path.
  localparam int BUF_DEPTH = 2;

  // Link clock period in the bench, in ns, and the local clock period in ns.
  localparam int LINK_PERIOD_NS = 400;
  localparam int CLK_PERIOD_NS = 50;
  // Link half period in local cycles, rounded down by integer division, with no lower bound.
  localparam int LINK_HALF_CYC = (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;

  // Reset values.
  localparam logic [FRAME_W-1:0] FRAME_RST = 16'h0000;

  // Snapshot of the state sent in one frame.
  typedef struct packed {
    logic [IN_W-1:0] inputs;
    logic uva_n;
    logic ota_n;
  } isb_snap_t;

  // Drive of the two serial outputs.
  typedef struct packed {
    logic true_o;
    logic inv_o;
    logic oe;
  } isb_drive_t;

endpackage

// File: hw/isb_buf2.sv
`timescale 1ns/1ps
// Two-entry buffer with valid and ready on both sides.
module isb_buf2 #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // Storage as flip-flops.
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;

  // Handshake decode.
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW-1:0] nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
  wire [AW-1:0] nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;

  assign in_ready = (cnt_ff != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];

  // Pointers and occupancy.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= nxt_wr;
      if (pop) rd_ff <= nxt_rd;
      cnt_ff <= cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  // Data storage, written without reset.
  always_ff @(posedge clk) begin
    if (push) mem_ff[wr_ff] <= in_data;
  end

endmodule // isb_buf2

// File: testbench/isb_props.sv
`timescale 1ns/1ps
// Checks pin drive and stream handshake of the serializer.
module isb_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Watched pins.
  input wire logic cs_n,
  input wire logic power_good,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso_n_o,
  input wire logic miso_n_oe,
  // Word stream.
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [isb_pkg::FRAME_W-1:0] rx_data,
  input wire logic rx_overrun
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Select held low, in any power state and with power lost.
  sequence s_sel; (!cs_n)[*5]; endsequence
  sequence s_loss; (!cs_n && !power_good)[*5]; endsequence
  oe_pair_a: assert property (miso_oe == miso_n_oe)
    else $error("enables differ");
  cs_float_a: assert property (cs_n[*5] |-> !miso_oe && !miso_n_oe)
    else $error("driven while idle");
  cs_drive_a: assert property (s_sel |-> miso_oe)
    else $error("not driven while selected");
  inv_compl_a: assert property (miso_oe |-> miso_n_o != miso_o)
    else $error("outputs not complementary");
  loss_drive_a: assert property (s_loss |-> !miso_o && miso_n_o)
    else $error("wrong drive on power loss");
  rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("word dropped while stalled");
  ovr_pulse_a: assert property (rx_overrun |=> !rx_overrun)
    else $error("overrun longer than one cycle");
  rx_load_a: assert property ($rose(rx_valid) |-> $past(rx_ready))
    else $error("word offered without ready");
endmodule // isb_props
bind isb_serializer isb_props u_isb_props (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .power_good(power_good),
  .miso_o(miso_o), .miso_oe(miso_oe), .miso_n_o(miso_n_o), .miso_n_oe(miso_n_oe), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .rx_data(rx_data), .rx_overrun(rx_overrun));

// File: testbench/isb_master.sv
`timescale 1ns/1ps
// Mode 0 bus master; its clock stands low between frames.
module isb_master (
  // Link pins.
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Sends tx MSB first, samples each bit late in the high phase.
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    #400;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = tx[i];
      #200 sck = 1'b1;
      #190 rx[i] = miso;
      #10 sck = 1'b0;
    end
    #200 cs_n = 1'b1;
    mosi = ~mosi;
    #600;
  endtask
endmodule // isb_master

// File: testbench/isb_serializer_test.sv
`timescale 1ns/1ps
// Self-checking bench: model frames and words against the design.
module isb_serializer_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic lo = 1'b0, hi = 1'b0, t_on = 1'b0, t_off = 1'b0, pg = 1'b1, rx_ready = 1'b1;
  logic uva_n = 1'b1, ota_n = 1'b1;
  logic [7:0] in_state = 8'h00;
  logic miso_o, miso_oe, miso_n_o, miso_n_oe, rx_valid, rx_overrun;
  logic [15:0] rx_data, got;
  logic [15:0] lf = 16'h44CD;
  int fails = 0, check_count = 0, ovr = 0, eovr = 0;
  logic [15:0] q[$];
  wire sck, cs_n, mosi;
  wire miso = miso_oe ? miso_o : 1'bz;
  always #25 clk = ~clk;
  isb_serializer u_isb_serializer (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .miso_n_o(miso_n_o), .miso_n_oe(miso_n_oe),
    .supply_voltage_monitor_lo(lo), .supply_voltage_monitor_hi(hi), .temp_above_on(t_on),
    .temp_below_off(t_off), .power_good(pg), .in_state(in_state), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_overrun(rx_overrun));
  isb_master u_isb_master (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  // Compares one value and counts the result.
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Expected frame from the snapshot.
  function automatic logic [15:0] frame(input logic [7:0] s, input logic u, input logic o);
    return {s, u, o, ~^{s[7:4], u}, ~^{s[7:6], s[3:2], o}, ~^{s[7], s[5], s[3], s[1], u},
      ~^{s[6], s[4], s[2], s[0], o}, 2'b01};
  endfunction
  // Next state of the stimulus shift register.
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Words taken from the stream leave in the order sent.
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) chk("rx_data", q.size() ? q.pop_front() : 16'hXXXX, rx_data);
    if (rx_overrun === 1'b1) ovr++;
  end
  // One frame with random alarms, word and a mid-frame input change.
  task automatic frame_run(input int n);
    logic [15:0] tx;
    logic [15:0] e;
    @(negedge clk);
    lf = lfsr_next(lf);
    tx = lf;
    {lo, hi, t_on, t_off} = lf[11:8];
    uva_n = lo ? 1'b0 : (hi ? 1'b1 : uva_n);
    ota_n = t_on ? 1'b0 : (t_off ? 1'b1 : ota_n);
    repeat (4) @(negedge clk);
    e = frame(in_state, uva_n, ota_n);
    if (n == 16 && !rx_ready && q.size() == 2) eovr++;
    else if (n == 16) q.push_back(tx);
    fork
      u_isb_master.xfer(tx, n, got);
      begin
        repeat (20) @(negedge clk);
        in_state = lf[15:8];
      end
    join
    chk("frame", pg ? e : 16'h0000, got);
  endtask
  // Ends the run with the verdict.
  task automatic print_verdict;
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    repeat (10) frame_run(16);
    @(negedge clk) rx_ready = 1'b0;
    repeat (3) frame_run(16);
    chk("overruns", 16'(eovr), 16'(ovr));
    @(negedge clk) rx_ready = 1'b1;
    // Stall again once a word is offered, so the held word is exercised.
    @(negedge clk) rx_ready = 1'b0;
    repeat (5) @(negedge clk);
    rx_ready = 1'b1;
    repeat (10) @(negedge clk);
    chk("drained", 16'h0000, 16'(q.size()));
    pg = 1'b0;
    frame_run(8);
    print_verdict;
  end
  // Cuts a hang short.
  initial begin
    #1000000;
    fails++;
    print_verdict;
  end
endmodule // isb_serializer_test
